// ===== design/breaker_trip_logic.sv
// Overcurrent trip decision logic with delay timers and latched indications
module breaker_trip_logic #(
  parameter int TICK_CYCLES = trip_pkg::TICK_CYCLES  // Clock cycles per millisecond tick
) (
  input wire logic clk,
  input wire logic rst,
  input wire trip_pkg::cur_t phase_current_a,
  input wire trip_pkg::cur_t phase_current_b,
  input wire trip_pkg::cur_t phase_current_c,
  input wire trip_pkg::cur_t ground_current,
  input wire trip_pkg::tap_t tap_sel,
  input wire trip_pkg::sel_t lt_pickup_sel,
  input wire trip_pkg::sel_t lt_delay_sel,
  input wire trip_pkg::sel_t st_pickup_sel,
  input wire trip_pkg::sel_t st_delay_sel,
  input wire trip_pkg::sel_t inst_pickup_sel,
  input wire trip_pkg::sel_t gf_pickup_sel,
  input wire trip_pkg::sel_t gf_delay_sel,
  input wire logic [1:0] defeat_sel,
  input wire logic gf_enable,
  input wire logic indicator_reset,
  input wire logic remote_reset,
  output logic trip,
  output logic ind_overload,
  output logic ind_short,
  output logic ind_ground,
  output logic comm_overload,
  output logic comm_short,
  output logic comm_ground,
  output logic comm_trip,
  output logic lt_timing_led,
  output logic power_led
);
  import trip_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  trip_state_t state;  // Registered state
  trip_state_t next_state;  // Next state
  cur_t i_max;  // Largest phase current
  cur_t eff_pct;  // Tapped rating
  cur_t lt_pu;  // Long time pickup
  cur_t st_pu;  // Short time pickup
  cur_t inst_pu;  // Instantaneous pickup
  cur_t gf_pu;  // Ground pickup
  acc_t i_sq;  // Square of phase current
  logic tick;  // Millisecond tick
  logic st_defeat;  // Short time switched out
  logic inst_defeat;  // Instantaneous switched out
  logic ramp_mode;  // Energy ramp position chosen
  logic lt_hit;  // Above long time pickup
  logic st_hit;  // Above short time pickup
  logic inst_hit;  // At instantaneous pickup
  logic disc_hit;  // Startup discriminator fires
  logic gf_hit;  // Above ground pickup
  logic st_trip;  // Short time delay complete
  logic ev_overload;  // Overload trip event
  logic ev_short;  // Short circuit trip event
  logic ev_ground;  // Ground fault trip event
  logic clear;  // Local or remote reset

  timer_if tif[NUM_TMR] ();  // Timer links

  ////////////////////////////////////////////////////////////////////////////
  // Timers
  generate
    for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
      delay_timer u_timer (
        .clk(clk),
        .rst(rst),
        .t(tif[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pickup levels and detection
  always_comb begin
    i_max = phase_current_a;
    if (phase_current_b > i_max) begin
      i_max = phase_current_b;
    end
    if (phase_current_c > i_max) begin
      i_max = phase_current_c;
    end
    i_sq = acc_t'(i_max) * acc_t'(i_max);
    // R17: tap scales phase pickups
    eff_pct = tap_pct(tap_sel);
    lt_pu = cur_t'((32'(eff_pct) * 32'(lt_pickup_pct(lt_pickup_sel))) / 32'd100);
    st_pu = cur_t'((32'(eff_pct) * 32'(st_mult_tenths(st_pickup_sel))) / 32'd10);
    inst_pu = cur_t'(32'(eff_pct) * 32'(inst_mult(inst_pickup_sel)));
    // R7: ground pickup ignores tap
    gf_pu = gf_pickup_pct(gf_pickup_sel);
    // R5: defeat selector
    st_defeat = (defeat_sel == DEFEAT_ST);
    inst_defeat = (defeat_sel == DEFEAT_INST);
    ramp_mode = (st_delay_sel == 4'(ST_RAMP_SEL));
    lt_hit = (i_max > lt_pu);
    // R6: short time out of service
    st_hit = (i_max > st_pu) && !st_defeat;
    inst_hit = (i_max >= inst_pu) && !inst_defeat;
    // R18: startup discriminator
    disc_hit = (state.boot == BOOT) && (i_max > cur_t'(DISC_PCT));
    gf_hit = gf_enable && (ground_current > gf_pu);
    // R14: remote contact treated as switch
    clear = indicator_reset || remote_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer requests
  always_comb begin
    tick = (state.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    // R15: setting times 36 pickup squared ms
    tif[TMR_LT].active = lt_hit;
    tif[TMR_LT].tick = tick;
    // R16: inverse square lengthens low overloads
    tif[TMR_LT].inc = i_sq;
    tif[TMR_LT].limit = acc_t'(lt_delay_s(lt_delay_sel)) * acc_t'(MS_PER_S * LT_REF_MULT * LT_REF_MULT)
                        * acc_t'(lt_pu) * acc_t'(lt_pu);
    // R1: fixed short time steps
    tif[TMR_ST].active = st_hit;
    tif[TMR_ST].tick = tick;
    tif[TMR_ST].inc = acc_t'(1);
    tif[TMR_ST].limit = fixed_delay_ms(st_delay_sel);
    // R21: energy ramp inverse square
    tif[TMR_RAMP].active = st_hit && ramp_mode;
    tif[TMR_RAMP].tick = tick;
    tif[TMR_RAMP].inc = i_sq;
    tif[TMR_RAMP].limit = acc_t'(RAMP_K_MS) * acc_t'(st_pu) * acc_t'(st_pu);
    // R8: ground delay steps
    tif[TMR_GF].active = gf_hit;
    tif[TMR_GF].tick = tick;
    tif[TMR_GF].inc = acc_t'(1);
    tif[TMR_GF].limit = fixed_delay_ms(gf_delay_sel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trip events
  always_comb begin
    // R2: short time after delay
    // R3: ramp and floor delay must both run out
    st_trip = tif[TMR_ST].expired && (!ramp_mode || tif[TMR_RAMP].expired);
    ev_overload = tif[TMR_LT].expired;
    // R4: instantaneous has no timer
    ev_short = st_trip || inst_hit || disc_hit;
    ev_ground = tif[TMR_GF].expired;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;
    // R20: fixed rate tick
    next_state.tick_cnt = tick ? '0 : state.tick_cnt + 1'b1;
    // Startup window
    case (state.boot)
      BOOT: begin
        if (tick) begin
          next_state.boot_ms = state.boot_ms + 1'b1;
          if (state.boot_ms == BOOT_W'(BOOT_WINDOW_MS - 1)) begin
            next_state.boot = RUN;
          end
        end
      end
      RUN: begin
        next_state.boot = RUN;
      end
      default: begin
        next_state.boot = RUN;
      end
    endcase
    next_state.trip = ev_overload || ev_short || ev_ground;
    // R9: latch cause, event beats reset
    // R10: reset clears indicators
    next_state.ind_overload = ev_overload || (state.ind_overload && !clear);
    next_state.ind_short = ev_short || (state.ind_short && !clear);
    next_state.ind_ground = ev_ground || (state.ind_ground && !clear);
    // R19: communication outputs latch
    next_state.comm_overload = ev_overload || (state.comm_overload && !clear);
    next_state.comm_short = ev_short || (state.comm_short && !clear);
    next_state.comm_ground = ev_ground || (state.comm_ground && !clear);
    next_state.comm_trip = next_state.trip || (state.comm_trip && !clear);
    // R11: overload light follows timing
    // R12: off below pickup
    next_state.lt_led = lt_hit;
    // R13: power light needs current
    next_state.power_led = (i_max >= cur_t'(POWER_MIN_PCT));
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs from flip-flops
  assign trip = state.trip;
  assign ind_overload = state.ind_overload;
  assign ind_short = state.ind_short;
  assign ind_ground = state.ind_ground;
  assign comm_overload = state.comm_overload;
  assign comm_short = state.comm_short;
  assign comm_ground = state.comm_ground;
  assign comm_trip = state.comm_trip;
  assign lt_timing_led = state.lt_led;
  assign power_led = state.power_led;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ground_latch;
    ev_ground ##1 (comm_ground && ind_ground && trip);
  endsequence

  sequence s_clear_all;
    !ind_overload && !ind_short && !ind_ground && !comm_overload && !comm_short && !comm_ground;
  endsequence

  inst_trip_now_a: assert property (inst_hit |=> trip && ind_short) // R4
    else $error("instantaneous pickup did not trip next cycle");
  st_defeat_hold_a: assert property (defeat_sel == DEFEAT_ST |-> !tif[TMR_ST].active && !st_trip) // R6
    else $error("short time ran while defeated");
  inst_defeat_a: assert property (inst_defeat && state.boot == RUN |-> ev_short == st_trip) // R5
    else $error("instantaneous acted while defeated");
  ground_latch_a: assert property (ev_ground |-> s_ground_latch) // R19
    else $error("ground event not latched");
  cause_hold_a: assert property (ind_overload && !clear |=> ind_overload) // R9
    else $error("overload indicator lost without reset");
  reset_clear_a: assert property (clear && !ev_overload && !ev_short && !ev_ground |=> s_clear_all) // R10
    else $error("reset did not clear indications");
  lt_led_follow_a: assert property (lt_hit |=> lt_timing_led) // R11
    else $error("overload light not lit during timing");
  lt_led_off_a: assert property (!lt_hit |=> !lt_timing_led ##1 1) // R12
    else $error("overload light stayed on below pickup");
  power_cause_a: assert property ($rose(power_led) |-> $past(i_max) >= cur_t'(POWER_MIN_PCT)) // R13
    else $error("power light lit on low current");
  tick_spacing_a: assert property (tick |=> !tick) // R20
    else $error("tick came back to back");
  boot_window_a: assert property (disc_hit |=> trip) // R18
    else $error("startup discriminator did not trip");
  ramp_floor_a: assert property (ramp_mode && ev_short && !inst_hit && !disc_hit |-> tif[TMR_ST].expired) // R21
    else $error("ramp trip came before floor delay");

endmodule

// ===== design/delay_timer.sv
// Tick driven delay accumulator that restarts when pickup is lost
module delay_timer (
  input wire logic clk,
  input wire logic rst,
  timer_if.timer t
);
  import trip_pkg::*;

  timer_state_t state;  // Registered state
  timer_state_t next_state;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Expiry seen from the register
  assign t.expired = t.active && (state.acc >= t.limit);

  // Next accumulator value
  always_comb begin
    next_state = state;
    // R20: restart on loss
    if (!t.active) begin
      next_state.acc = '0;
    end else if (t.tick && (state.acc < t.limit)) begin
      next_state.acc = state.acc + t.inc;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  restart_clear_a: assert property (!t.active |=> state.acc == '0) // R20
    else $error("timer did not restart after pickup loss");
  tick_advance_a: assert property (t.active && t.tick && state.acc < t.limit && $stable(t.active)
    |=> state.acc == $past(state.acc) + $past(t.inc)) // R20
    else $error("timer did not advance on tick");
  hold_still_a: assert property (t.active && !t.tick |=> !t.active || state.acc == $past(state.acc)) // R20
    else $error("timer moved without tick");

endmodule

// ===== pkg/timer_if.sv
// Link between the trip logic and one delay timer
interface timer_if;
  import trip_pkg::*;
  logic tick;  // Millisecond tick
  logic active;  // Pickup condition present
  acc_t inc;  // Amount added on each tick
  acc_t limit;  // Amount that ends the delay
  logic expired;  // Delay has run out
  modport ctrl(output tick, output active, output inc, output limit, input expired);
  modport timer(input tick, input active, input inc, input limit, output expired);
endinterface

// ===== pkg/trip_pkg.sv
// Constants, types and switch decoders for the breaker trip decision logic
// What this block does
// R1: Short time delay: nine steps 0.1-0.5 s
// R2: Short time trip after delay above pickup
// R3: Last short time step adds energy ramp
// R4: Instantaneous pickup trips with no timer
// R5: Defeat selector disables short time or instantaneous
// R6: Short time defeated: trip only at instantaneous
// R7: Ground pickup uses sensor rating, not tap
// R8: Ground trip delayed 0.1-0.5 s steps
// R9: Latch fault cause indicator until reset
// R10: Indicator reset clears indicators and outputs
// R11: Overload light on when long time times
// R12: Overload light off, timing stops below pickup
// R13: Power light only with sufficient current
// R14: Remote contact closure acts as reset switch
// R15: Long time delays named at 600 percent
// R16: Long time delay lengthens as current falls
// R17: Tap scales phase pickups, not ground
// R18: Startup window trips above twelve times rating
// R19: Communication outputs latch until reset
// R20: Delays counted on fixed tick, restart on loss
// R21: Energy ramp delay inverse square, floored
package trip_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and types
  localparam int CUR_W = 16;  // Currents in percent of sensor rating
  localparam int ACC_W = 48;  // Timer accumulators
  localparam int SEL_W = 4;  // Ten-position switches
  localparam int TAP_W = 3;  // Six-position tap switch
  localparam int TICK_W = 18;  // Tick prescaler width
  localparam int BOOT_W = 8;  // Startup window counter width

  typedef logic [CUR_W-1:0] cur_t;
  typedef logic [ACC_W-1:0] acc_t;
  typedef logic [SEL_W-1:0] sel_t;
  typedef logic [TAP_W-1:0] tap_t;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_FREQ_HZ = 200_000_000;
  localparam int TICK_PERIOD_US = 1000;  // One millisecond tick
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int BOOT_WINDOW_MS = 128;  // Discriminator window length
  localparam int MS_PER_S = 1000;
  localparam int FIXED_BASE_MS = 100;  // First fixed delay step
  localparam int FIXED_STEP_MS = 50;  // Delay increment
  localparam int FIXED_LAST_SEL = 8;  // Ninth fixed step, longest delay
  localparam int ST_RAMP_SEL = 9;  // Energy ramp position
  localparam int RAMP_K_MS = 1650;  // Ramp delay in ms at pickup current
  localparam int LT_REF_MULT = 6;  // Long time delays named at 600 percent

  ////////////////////////////////////////////////////////////////////////////
  // Levels in percent of sensor rating
  localparam int DISC_PCT = 1200;  // Twelve times rating
  localparam int POWER_MIN_PCT = 20;  // Least current to run the unit

  ////////////////////////////////////////////////////////////////////////////
  // Defeat selector codes
  localparam logic [1:0] DEFEAT_NONE = 2'h0;
  localparam logic [1:0] DEFEAT_ST = 2'h1;
  localparam logic [1:0] DEFEAT_INST = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timer slots
  localparam int NUM_TMR = 4;
  localparam int TMR_LT = 0;
  localparam int TMR_ST = 1;
  localparam int TMR_RAMP = 2;
  localparam int TMR_GF = 3;

  ////////////////////////////////////////////////////////////////////////////
  // State types
  typedef enum logic [1:0] {
    BOOT = 2'b00,  // Discriminator window open
    RUN = 2'b01  // Normal protection
  } boot_state_t;

  typedef struct packed {
    acc_t acc;  // Ticks or energy gathered
  } timer_state_t;

  typedef struct packed {
    boot_state_t boot;
    logic [BOOT_W-1:0] boot_ms;
    logic [TICK_W-1:0] tick_cnt;
    logic trip;
    logic ind_overload;
    logic ind_short;
    logic ind_ground;
    logic comm_overload;
    logic comm_short;
    logic comm_ground;
    logic comm_trip;
    logic lt_led;
    logic power_led;
  } trip_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Switch decoders
  // Tap in percent of sensor rating
  function automatic cur_t tap_pct(input tap_t sel);
    tap_pct = (sel > 3'h5) ? cur_t'(100) : cur_t'(50 + 10 * int'(sel));
  endfunction

  // Long time pickup in percent of the tapped rating
  function automatic cur_t lt_pickup_pct(input sel_t sel);
    case (sel)
      4'h0: lt_pickup_pct = 16'h0028;
      4'h1: lt_pickup_pct = 16'h002D;
      4'h2: lt_pickup_pct = 16'h0032;
      4'h3: lt_pickup_pct = 16'h0037;
      4'h4: lt_pickup_pct = 16'h003C;
      4'h5: lt_pickup_pct = 16'h0046;
      4'h6: lt_pickup_pct = 16'h004B;
      4'h7: lt_pickup_pct = 16'h0050;
      4'h8: lt_pickup_pct = 16'h005A;
      default: lt_pickup_pct = 16'h0064;
    endcase
  endfunction

  // Long time delay in seconds at 600 percent of pickup
  function automatic cur_t lt_delay_s(input sel_t sel);
    case (sel)
      4'h0: lt_delay_s = 16'h0002;
      4'h1: lt_delay_s = 16'h0003;
      4'h2: lt_delay_s = 16'h0004;
      4'h3: lt_delay_s = 16'h0005;
      4'h4: lt_delay_s = 16'h0007;
      4'h5: lt_delay_s = 16'h000A;
      4'h6: lt_delay_s = 16'h000C;
      4'h7: lt_delay_s = 16'h000F;
      4'h8: lt_delay_s = 16'h0014;
      default: lt_delay_s = 16'h0018;
    endcase
  endfunction

  // Short time pickup in tenths of the tapped rating
  function automatic cur_t st_mult_tenths(input sel_t sel);
    st_mult_tenths = (sel == 4'h0) ? cur_t'(15) : (sel > 4'h9) ? cur_t'(100) : cur_t'(10 * (int'(sel) + 1));
  endfunction

  // Instantaneous pickup in multiples of the tapped rating
  function automatic cur_t inst_mult(input sel_t sel);
    inst_mult = (sel >= 4'h9) ? cur_t'(12) : cur_t'(int'(sel) + 2);
  endfunction

  // Ground pickup in percent of sensor rating
  function automatic cur_t gf_pickup_pct(input sel_t sel);
    gf_pickup_pct = (sel > 4'h9) ? cur_t'(65) : cur_t'(20 + 5 * int'(sel));
  endfunction

  // Fixed delay steps shared by short time and ground fault
  function automatic acc_t fixed_delay_ms(input sel_t sel);
    fixed_delay_ms = (sel > 4'(FIXED_LAST_SEL)) ? acc_t'(FIXED_BASE_MS + FIXED_STEP_MS * FIXED_LAST_SEL)
                                                : acc_t'(FIXED_BASE_MS + FIXED_STEP_MS * int'(sel));
  endfunction

endpackage

// ===== sim/current_source_model.sv
// Behavioural current sensors and breaker actuator facing the trip logic
module current_source_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic trip,
  input wire logic reclose,
  input wire trip_pkg::cur_t demand_phase,
  input wire trip_pkg::cur_t demand_ground,
  output trip_pkg::cur_t phase_current_a,
  output trip_pkg::cur_t phase_current_b,
  output trip_pkg::cur_t phase_current_c,
  output trip_pkg::cur_t ground_current
);
  timeunit 1ns;
  timeprecision 1ps;
  import trip_pkg::*;

  logic closed;  // Breaker contacts closed

  ////////////////////////////////////////////////////////////////////////////
  // Actuator opens the breaker on a trip command, the bench recloses it
  always_ff @(posedge clk) begin
    if (rst || reclose) begin
      closed <= 1'b1;
    end else if (trip) begin
      closed <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open contacts carry no current; phases b and c run lighter than a
  assign phase_current_a = closed ? demand_phase : '0;
  assign phase_current_b = closed ? (demand_phase >> 1) : '0;
  assign phase_current_c = closed ? (demand_phase >> 2) : '0;
  assign ground_current = closed ? demand_ground : '0;
endmodule

// ===== sim/tb_breaker_trip_timing_logic.sv
// Self-checking bench for the breaker trip decision logic
module tb_breaker_trip_timing_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import trip_pkg::*;

  localparam int TK = 10;  // Clock cycles per shortened millisecond tick
  logic clk = 1'b0;
  logic rst = 1'b1;
  cur_t ia, ib, ic, ig, dem_p, dem_g;
  tap_t tap;
  sel_t lt_pu, lt_dl, st_pu, st_dl, inst_pu, gf_pu, gf_dl;
  logic [1:0] defeat;
  logic gf_en, loc_rst, rem_rst, reclose;
  logic trip, ind_ol, ind_sc, ind_gf, c_ol, c_sc, c_gf, c_tr, lt_led, pwr_led;
  int fails = 0;
  int check_count = 0;

  // Clock at 200 MHz
  always #2.5 clk = ~clk;

  current_source_model partner (.clk(clk), .rst(rst), .trip(trip), .reclose(reclose), .demand_phase(dem_p),
    .demand_ground(dem_g), .phase_current_a(ia), .phase_current_b(ib), .phase_current_c(ic), .ground_current(ig));

  breaker_trip_logic #(.TICK_CYCLES(TK)) dut (.clk(clk), .rst(rst), .phase_current_a(ia), .phase_current_b(ib),
    .phase_current_c(ic), .ground_current(ig), .tap_sel(tap), .lt_pickup_sel(lt_pu), .lt_delay_sel(lt_dl),
    .st_pickup_sel(st_pu), .st_delay_sel(st_dl), .inst_pickup_sel(inst_pu), .gf_pickup_sel(gf_pu),
    .gf_delay_sel(gf_dl), .defeat_sel(defeat), .gf_enable(gf_en), .indicator_reset(loc_rst),
    .remote_reset(rem_rst), .trip(trip), .ind_overload(ind_ol), .ind_short(ind_sc), .ind_ground(ind_gf),
    .comm_overload(c_ol), .comm_short(c_sc), .comm_ground(c_gf), .comm_trip(c_tr), .lt_timing_led(lt_led),
    .power_led(pwr_led));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic tally_and_finish();
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Advance n cycles, landing just after the rising edge
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Compare one value and report a mismatch
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Apply currents and require the trip inside a cycle window
  task automatic run(input cur_t p, input cur_t g, input int lo, input int hi);
    int n;
    n = 0;
    dem_p = p;
    dem_g = g;
    while (trip !== 1'b1 && n <= hi) begin
      step(1);
      n++;
    end
    check("trip delay in window", 32'h1, 32'(n >= lo && n <= hi));
    // A trip that never came cuts the run short
    if (trip !== 1'b1) begin
      tally_and_finish();
    end
  endtask

  // Remove current, press a reset and reclose the breaker
  task automatic clear(input logic remote);
    dem_p = '0;
    dem_g = '0;
    rem_rst = remote;
    loc_rst = ~remote;
    reclose = 1'b1;
    step(1);
    rem_rst = 1'b0;
    loc_rst = 1'b0;
    reclose = 1'b0;
    step(1);
    check("latched outputs", 32'h0, {ind_ol, ind_sc, ind_gf, c_ol, c_sc, c_gf, c_tr});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {dem_p, dem_g, lt_dl, st_dl, gf_pu, gf_dl} = '0;
    {gf_en, loc_rst, rem_rst, reclose} = '0;
    tap = 3'h5;
    lt_pu = 4'h9;
    lt_dl = 4'h9;
    st_pu = 4'h9;
    inst_pu = 4'h9;
    defeat = DEFEAT_INST;
    step(3);
    rst = 1'b0;
    // Startup bolted fault trips at once even with instantaneous defeated
    run(16'h0514, 16'h0000, 1, 2);
    check("short indicator", 32'h1, ind_sc);
    clear(1'b0);
    step(1300);
    defeat = DEFEAT_NONE;
    // Power light threshold
    dem_p = 16'h000A;
    step(2);
    check("power led low", 32'h0, pwr_led);
    dem_p = 16'h001E;
    step(2);
    check("power led high", 32'h1, pwr_led);
    // Overload light follows the long time pickup
    dem_p = 16'h006E;
    step(3);
    check("lt led on", 32'h1, lt_led);
    step(50);
    check("lt led held", 32'h1, lt_led);
    dem_p = 16'h005A;
    step(3);
    check("lt led off", 32'h0, lt_led);
    // Long time at ten times a 40 percent pickup, 2 s setting: 2*1000*36/100 = 720 ticks
    lt_pu = 4'h0;
    lt_dl = 4'h0;
    run(16'h0190, 16'h0000, 719 * TK, 720 * TK + 12);
    check("overload cause", 32'h6, {ind_ol, c_ol, ind_sc});
    clear(1'b0);
    lt_pu = 4'h9;
    lt_dl = 4'h9;
    // Instantaneous at two times tapped rating, just below first
    inst_pu = 4'h0;
    dem_p = 16'h00C7;
    step(5);
    check("no trip below inst", 32'h0, trip);
    run(16'h00C8, 16'h0000, 1, 2);
    check("short cause", 32'h7, {ind_sc, c_sc, c_tr});
    step(5);
    check("indication held open", 32'h3, {trip, ind_sc, c_sc});
    clear(1'b1);
    // Every fixed short time step, instantaneous defeated
    defeat = DEFEAT_INST;
    st_pu = 4'h0;
    for (int s = 0; s <= 8; s++) begin
      st_dl = 4'(s);
      run(16'h012C, 16'h0000, (FIXED_BASE_MS + FIXED_STEP_MS * s - 1) * TK,
          (FIXED_BASE_MS + FIXED_STEP_MS * s) * TK + 12);
      check("short not overload", 32'h1, {ind_ol, ind_sc});
      clear(1'b0);
    end
    // Energy ramp: inverse square with a fixed floor
    st_dl = 4'(ST_RAMP_SEL);
    run(16'h00A0, 16'h0000, 1450 * TK, 1451 * TK + 12);
    clear(1'b0);
    run(16'h012C, 16'h0000, 499 * TK, 500 * TK + 12);
    clear(1'b0);
    // Short time defeated waits for the instantaneous level
    defeat = DEFEAT_ST;
    st_dl = 4'h0;
    inst_pu = 4'h8;
    dem_p = 16'h01F4;
    step(1500);
    check("no short time trip", 32'h0, trip);
    run(16'h03E8, 16'h0000, 1, 2);
    clear(1'b0);
    // Ground pickup ignores the tap, then delay bands 0, 4 and 8
    defeat = DEFEAT_NONE;
    inst_pu = 4'h9;
    tap = 3'h0;
    gf_en = 1'b1;
    dem_g = 16'h000F;
    step(1500);
    check("ground below pickup", 32'h0, trip);
    for (int s = 0; s <= 8; s += 4) begin
      gf_dl = 4'(s);
      run(16'h0000, 16'h0019, (FIXED_BASE_MS + FIXED_STEP_MS * s - 1) * TK,
          (FIXED_BASE_MS + FIXED_STEP_MS * s) * TK + 12);
      check("ground cause", 32'h3, {ind_gf, c_gf});
      clear(1'b1);
    end
    // Half tap halves the phase pickups: instantaneous now at six times rating
    run(16'h0258, 16'h0000, 1, 2);
    check("tapped inst cause", 32'h1, ind_sc);
    clear(1'b0);
    tally_and_finish();
  end
endmodule
